// [pkg/odag_consts.vh]
/*
 constants for the debug access gate: register offset, field positions,
 reset values, tap instruction codes, break point counts.
 assumes inclusion by bare name from core files.
*/
`ifndef ODAG_CONSTS_VH
`define ODAG_CONSTS_VH
`define ODAG_DDR_OFFSET 6'h22
`define ODAG_DDR_RESET 8'h00
`define ODAG_DIRTY_BIT 7
`define ODAG_IR_PRIV_A 4'h8
`define ODAG_IR_PRIV_B 4'h9
`define ODAG_IR_PRIV_C 4'hA
`define ODAG_IR_PRIV_D 4'hB
`define ODAG_IR_PRIV_MASK 4'hC
`define ODAG_IR_RESET 4'hF
`define ODAG_PROG_BP_NUM 2
`define ODAG_TMS_RESET_CNT 3'h5
`define ODAG_SHIFT_W 8
`endif

// [core/odag_sync.v]
/*
 two flip-flop synchroniser for one level from outside clk_sys.
 assumes the input is asynchronous and a one-bit level.
*/
module odag_sync (
    input wire clk_sys,
    input wire rst,
    input wire async_in,
    output wire sync_out
);
    reg meta_q;
    reg sync_q;

    // first stage feeds only the second
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;
endmodule

// [core/odag_gate.v]
/*
 on-chip debug access gate: sampled tap front end with a private
 debug data path, fuse and lock gating, cpu data register with dirty
 flag, and a break point compare unit.
 assumes tck, tms, tdi arrive from pins on an unrelated clock and run
 well below clk_sys; cpu io port is on clk_sys.
*/
`include "odag_consts.vh"
module odag_gate #(
    parameter IR_W = 4,
    parameter PA_W = 16,
    parameter DA_W = 16
) (
    input wire clk_sys,
    input wire rst,
    input wire tap_enable_fuse,
    input wire debug_enable_fuse,
    input wire [1:0] lock_bits,
    input wire tck,
    input wire tms,
    input wire tdi,
    output wire tdo,
    output wire tdo_oe,
    input wire [5:0] io_addr,
    input wire io_wr,
    input wire io_rd,
    input wire [7:0] io_wdata,
    output wire [7:0] io_rdata,
    input wire [2*PA_W-1:0] bp_prog_addr,
    input wire [1:0] bp_prog_en,
    input wire [DA_W-1:0] bp_data_addr,
    input wire [DA_W-1:0] bp_data_mask,
    input wire bp_data_en,
    input wire [PA_W-1:0] cpu_pc,
    input wire [DA_W-1:0] cpu_daddr,
    input wire cpu_dacc,
    output wire debug_active,
    output wire private_instr,
    output wire break_req
);
    localparam S_RESET = 6'h01;
    localparam S_IDLE = 6'h02;
    localparam S_SEL = 6'h04;
    localparam S_CAP = 6'h08;
    localparam S_SHIFT = 6'h10;
    localparam S_UPD = 6'h20;

    wire tck_s;
    wire tms_s;
    wire tdi_s;
    reg tck_prev_q;
    reg [5:0] st_q;
    reg [5:0] st_d;
    reg ir_sel_q;
    reg [2:0] tms_cnt_q;
    reg [IR_W-1:0] ir_q;
    reg [`ODAG_SHIFT_W-1:0] sh_q;
    reg [7:0] ddr_q;
    reg dirty_q;
    reg tdo_q;
    reg brk_q;
    reg [7:0] rdata_q;
    wire rise;
    wire fall;
    wire tap_on;
    wire dbg_on;
    wire sel_ddr;
    wire [1:0] pm_hit;
    wire dm_hit;

    odag_sync u_s_tck (.clk_sys(clk_sys), .rst(rst), .async_in(tck), .sync_out(tck_s));
    odag_sync u_s_tms (.clk_sys(clk_sys), .rst(rst), .async_in(tms), .sync_out(tms_s));
    odag_sync u_s_tdi (.clk_sys(clk_sys), .rst(rst), .async_in(tdi), .sync_out(tdi_s));

    // tap fuse gates the whole path; debug fuse and lock bits gate only the debug side
    assign tap_on = tap_enable_fuse;
    assign dbg_on = tap_on & debug_enable_fuse & ~(|lock_bits);
    assign rise = tap_on & tck_s & ~tck_prev_q;
    assign fall = tap_on & ~tck_s & tck_prev_q;
    assign sel_ddr = (io_addr == `ODAG_DDR_OFFSET);
    // private window is 0x8..0xB: top bits 10
    assign private_instr = dbg_on & ((ir_q & `ODAG_IR_PRIV_MASK) == `ODAG_IR_PRIV_A);

    // simplified tap walk: each pass through sel alternates ir and dr, ir first after idle
    always @* begin
        st_d = st_q;
        case (st_q)
            S_RESET: begin
                st_d = tms_s ? S_RESET : S_IDLE;
            end
            S_IDLE: begin
                st_d = tms_s ? S_SEL : S_IDLE;
            end
            S_SEL: begin
                st_d = tms_s ? S_RESET : S_CAP;
            end
            S_CAP: begin
                st_d = tms_s ? S_UPD : S_SHIFT;
            end
            S_SHIFT: begin
                st_d = tms_s ? S_UPD : S_SHIFT;
            end
            S_UPD: begin
                st_d = tms_s ? S_SEL : S_IDLE;
            end
            default: begin
                st_d = S_RESET;
            end
        endcase
    end

    // tap state, ir, shifter on sampled tck rising edge
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            tck_prev_q <= 1'b0;
            st_q <= S_RESET;
            ir_sel_q <= 1'b0;
            tms_cnt_q <= 3'h0;
            ir_q <= `ODAG_IR_RESET;
            sh_q <= {`ODAG_SHIFT_W{1'b0}};
        end else begin
            tck_prev_q <= tck_s;
            if (!tap_on) begin
                // fuse off holds the port in reset
                st_q <= S_RESET;
                ir_q <= `ODAG_IR_RESET;
                tms_cnt_q <= 3'h0;
            end else if (rise) begin
                if (tms_s && tms_cnt_q == `ODAG_TMS_RESET_CNT - 3'h1) begin
                    st_q <= S_RESET;
                end else begin
                    st_q <= st_d;
                end
                if (!tms_s) begin
                    tms_cnt_q <= 3'h0;
                end else if (tms_cnt_q != `ODAG_TMS_RESET_CNT) begin
                    tms_cnt_q <= tms_cnt_q + 3'h1;
                end
                if (st_q == S_RESET) begin
                    ir_q <= `ODAG_IR_RESET;
                end
                if (st_q == S_IDLE && tms_s) begin
                    ir_sel_q <= 1'b0;
                end else if (st_q == S_SEL && !tms_s) begin
                    ir_sel_q <= ~ir_sel_q;
                end
                if (st_q == S_CAP) begin
                    // debug dr captures cpu byte, dirty flag on top
                    if (private_instr && !ir_sel_q) begin
                        sh_q <= {dirty_q, ddr_q[`ODAG_DIRTY_BIT-1:0]};
                    end else begin
                        sh_q <= {`ODAG_SHIFT_W{1'b0}};
                    end
                end else if (st_q == S_SHIFT) begin
                    sh_q <= {tdi_s, sh_q[`ODAG_SHIFT_W-1:1]};
                end
                if (st_q == S_UPD && ir_sel_q) begin
                    ir_q <= sh_q[`ODAG_SHIFT_W-1:`ODAG_SHIFT_W-IR_W];
                end
            end
        end
    end

    // tdo changes on falling tck, driven only while shifting
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            tdo_q <= 1'b0;
        end else if (fall) begin
            tdo_q <= sh_q[0];
        end
    end
    assign tdo = tdo_q;
    assign tdo_oe = tap_on & (st_q == S_SHIFT);

    // cpu data register; debugger read is update of a private dr scan
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ddr_q <= `ODAG_DDR_RESET;
            dirty_q <= 1'b0;
        end else begin
            if (io_wr && sel_ddr) begin
                ddr_q <= io_wdata;
            end
            if (io_wr && sel_ddr && dbg_on) begin
                dirty_q <= 1'b1; // set wins over clear
            end else if (!dbg_on) begin
                dirty_q <= 1'b0;
            end else if (rise && st_q == S_UPD && !ir_sel_q && private_instr) begin
                dirty_q <= 1'b0;
            end
        end
    end

    // read view: plain memory when debug off, dirty in bit 7 when on
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rdata_q <= 8'h00;
        end else if (io_rd && sel_ddr) begin
            rdata_q <= dbg_on ? {dirty_q, ddr_q[`ODAG_DIRTY_BIT-1:0]} : ddr_q;
        end else begin
            rdata_q <= 8'h00;
        end
    end
    assign io_rdata = rdata_q;

    // program memory break point compares, one per slot
    genvar g;
    generate
        for (g = 0; g < `ODAG_PROG_BP_NUM; g = g + 1) begin : g_pbp
            assign pm_hit[g] = bp_prog_en[g] & (cpu_pc == bp_prog_addr[g*PA_W +: PA_W]);
        end
    endgenerate
    // masked data compare gives a range break point
    assign dm_hit = bp_data_en & cpu_dacc &
        (((cpu_daddr ^ bp_data_addr) & ~bp_data_mask) == {DA_W{1'b0}});

    // break only reaches cpu while debug is allowed
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            brk_q <= 1'b0;
        end else begin
            brk_q <= dbg_on & ((|pm_hit) | dm_hit);
        end
    end
    assign break_req = brk_q;
    assign debug_active = dbg_on;
endmodule

// [bench/odag_props.sv]
/* checker on odag_gate ports: gating, io answers, break hits.
   assumes a bind onto odag_gate, clk_sys with async rst high. */
module odag_props #(parameter PA_W = 16) (
    input wire clk_sys,
    input wire rst,
    input wire tap_enable_fuse,
    input wire debug_enable_fuse,
    input wire [1:0] lock_bits,
    input wire tdo_oe,
    input wire [5:0] io_addr,
    input wire io_wr,
    input wire io_rd,
    input wire [7:0] io_wdata,
    input wire [7:0] io_rdata,
    input wire [2*PA_W-1:0] bp_prog_addr,
    input wire [1:0] bp_prog_en,
    input wire [PA_W-1:0] cpu_pc,
    input wire debug_active,
    input wire private_instr,
    input wire break_req
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    // gating is combinational, so each gating check holds in the same cycle; p_bp waits one cycle for the registered break
    property p_tap_off; !tap_enable_fuse |-> !tdo_oe && !private_instr; endproperty
    property p_dbg_on;
        debug_active == (tap_enable_fuse && debug_enable_fuse && lock_bits == 2'h0);
    endproperty
    property p_lock; |lock_bits |-> !debug_active && !private_instr; endproperty
    property p_priv; private_instr |-> debug_active; endproperty
    property p_bp;
        debug_active && bp_prog_en[0] && cpu_pc == bp_prog_addr[PA_W-1:0] |=> break_req;
    endproperty
    // cpu write, gap, cpu read: byte back with the dirty flag up
    property p_dirty;
        debug_active && io_wr && io_addr == 6'h22 ##2 io_rd && io_addr == 6'h22
            |=> io_rdata[7] && io_rdata[6:0] == $past(io_wdata[6:0], 3);
    endproperty
    property p_refuse; io_rd && io_addr != 6'h22 |=> io_rdata == 8'h00; endproperty
    a_tap_off: assert property (p_tap_off) else $error("tap live with fuse off");
    a_dbg_on: assert property (p_dbg_on) else $error("debug enable wrong");
    a_lock: assert property (p_lock) else $error("debug live while locked");
    a_priv: assert property (p_priv) else $error("private code while off");
    a_bp: assert property (p_bp) else $error("missed program break");
    a_dirty: assert property (p_dirty) else $error("dirty byte wrong");
    a_refuse: assert property (p_refuse) else $error("unmapped read not zero");
    c_priv: cover property (private_instr);
    c_brk: cover property (break_req);
    c_lock: cover property (tap_enable_fuse && debug_enable_fuse && |lock_bits);
endmodule

bind odag_gate odag_props #(.PA_W(PA_W)) i_odag_props (.*);

// [bench/odag_dbg_host.sv]
/* debugger model: scans ir then dr over the tap pins, tck 64 ns.
   assumes the gate samples tck on its own clock; tck idles low. */
module odag_dbg_host (
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] got;
    logic [7:0] res;
    logic [27:0] tdi_v;
    logic [27:0] tms_v;
    integer i;
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end
    // tdo read mid-high: the gate only moves it after the fall
    task bit_t(input logic m, input logic d);
        tms = m;
        tdi = d;
        #32 tck = 1'b1;
        #16 got = {tdo, got[7:1]};
        #16 tck = 1'b0;
    endtask
    // reset, ir scan of code, dr scan, back to idle
    task access(input logic [3:0] code);
        tdi_v = {11'h000, code, 13'h0000}; // ir code in the top nibble, lsb first
        tms_v = 28'h803005F; // five tms high first
        for (i = 0; i < 28; i++) bit_t(tms_v[i], tdi_v[i]);
        res = got;
        bit_t(1'b0, 1'b0);
        tdi = 1'b1; // released line shows no stale value
    endtask
endmodule

// [bench/odag_gate_bench.sv]
/* bench for odag_gate: fuse sweep, debugger scans, io reads, breaks.
   assumes odag_dbg_host on the tap pins and the bound checker. */
module odag_gate_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys = 1'b0, rst = 1'b1, io_wr = 1'b0, io_rd = 1'b0, cpu_dacc = 1'b0;
    logic tap_enable_fuse = 1'b1, debug_enable_fuse = 1'b1, bp_data_en = 1'b1;
    logic [1:0] lock_bits = 2'h0, bp_prog_en = 2'h3;
    logic [5:0] io_addr = 6'h00;
    logic [7:0] io_wdata = 8'h00, d;
    logic [31:0] bp_prog_addr = 32'h01000040;
    logic [15:0] bp_data_addr = 16'h1230, bp_data_mask = 16'h000F;
    logic [15:0] cpu_pc = 16'hFFFF, cpu_daddr = 16'h0000;
    wire tck, tms, tdi, tdo, tdo_oe, debug_active, private_instr, break_req;
    wire [7:0] io_rdata;
    // tdo pin pulled up whenever the gate lets go of it
    wire tdo_line = tdo_oe ? tdo : 1'b1;
    integer seed = 33, error_cnt = 0, compares = 0, i;
    odag_gate i_odag_gate (.*);
    odag_dbg_host i_odag_dbg_host (
        .tck(tck),
        .tms(tms),
        .tdi(tdi),
        .tdo(tdo_line)
    );
    always #4 clk_sys = ~clk_sys;
    function logic prv(input logic [3:0] c);
        prv = c[3:2] == 2'b10;
    endfunction
    task chk(input logic [7:0] g, input logic [7:0] e);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("Error at %0t: got %h exp %h", $time, g, e);
        end
    endtask
    // one strobe; read data stands in the next cycle
    task io(input logic w, input logic [5:0] a, input logic [7:0] v);
        @(negedge clk_sys);
        io_wr = w;
        io_rd = !w;
        io_addr = a;
        io_wdata = v;
        @(negedge clk_sys);
        io_wr = 1'b0;
        io_rd = 1'b0;
    endtask
    task bp(input logic [15:0] pc, input logic [15:0] da, input logic e);
        @(negedge clk_sys);
        cpu_pc = pc;
        cpu_daddr = da;
        cpu_dacc = 1'b1;
        @(negedge clk_sys);
        chk(break_req, e);
    endtask
    task wrap_up;
        $display("compares %0d errors %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (8) @(posedge clk_sys);
        @(negedge clk_sys) rst = 1'b0;
        for (i = 0; i < 16; i++) begin
            @(negedge clk_sys) {tap_enable_fuse, debug_enable_fuse, lock_bits} = $random(seed);
            #1 chk(debug_active, tap_enable_fuse & debug_enable_fuse & ~|lock_bits);
        end
        {tap_enable_fuse, debug_enable_fuse, lock_bits} = 4'hC;
        $display("fuse sweep done");
        for (i = 7; i < 13; i++) begin
            d = $random(seed);
            io(1'b1, 6'h22, d);
            io(1'b0, 6'h22, 8'h00);
            chk(io_rdata, {1'b1, d[6:0]});
            i_odag_dbg_host.access(i[3:0]);
            chk(i_odag_dbg_host.res, prv(i[3:0]) ? {1'b1, d[6:0]} : 8'h00);
            chk(private_instr, prv(i[3:0]));
            io(1'b0, 6'h22, 8'h00);
            chk(io_rdata, {!prv(i[3:0]), d[6:0]});
        end
        io(1'b0, 6'h21, 8'h00);
        chk(io_rdata, 8'h00);
        $display("scan test done");
        lock_bits = 2'h2;
        d = $random(seed);
        io(1'b1, 6'h22, d);
        i_odag_dbg_host.access(4'h8);
        chk(i_odag_dbg_host.res, 8'h00);
        io(1'b0, 6'h22, 8'h00);
        chk(io_rdata, d);
        {tap_enable_fuse, lock_bits} = 3'h0;
        i_odag_dbg_host.access(4'h9);
        chk(private_instr, 1'b0);
        chk(i_odag_dbg_host.res, 8'hFF);
        tap_enable_fuse = 1'b1;
        io(1'b0, 6'h22, 8'h00);
        chk(io_rdata, {1'b0, d[6:0]});
        chk(private_instr, 1'b0);
        $display("gating test done");
        bp(16'h0040, 16'h0000, 1'b1);
        bp(16'h0100, 16'h0000, 1'b1);
        bp(16'hFFFF, 16'h123A, 1'b1);
        bp(16'hFFFF, 16'h1240, 1'b0);
        $display("break test done");
        wrap_up;
    end
    // watchdog
    initial begin
        #60000;
        error_cnt++;
        $display("Error at %0t: watchdog", $time);
        wrap_up;
    end
endmodule
